// ---- verilog/urxf_pkg.sv ----
`default_nettype none
package urxf_pkg;
  // Storage word layout: data byte plus three status bits
  localparam int DATA_W = 8;
  localparam int STAT_W = 3;
  localparam int WORD_W = DATA_W + STAT_W;
  localparam int FIFO_DEPTH = 256;
  localparam int STAGE_DEPTH = 8;
  // Status positions inside the stored word (upper bits of status register)
  localparam int ST_BREAK_POS = 10;
  localparam int ST_FRAME_POS = 9;
  localparam int ST_PARITY_POS = 8;
  // Status register bit positions
  localparam int SR_OVERRUN_POS = 4;
  localparam int SR_ADFLAG_POS = 5;
  // Parity field code that selects multi-drop
  localparam logic [1:0] PARITY_MULTIDROP = 2'h3;
  // Multi-drop sub-modes
  localparam logic [1:0] MD_HOST = 2'h0;
  localparam logic [1:0] MD_WAKE = 2'h1;
  localparam logic [1:0] MD_DOZE = 2'h2;
  localparam logic [1:0] MD_BOTH = 2'h3;
  // Bid offset levels, one per offset code
  localparam logic [8:0] BID_LVL0 = 9'h001;
  localparam logic [8:0] BID_LVL1 = 9'h040;
  localparam logic [8:0] BID_LVL2 = 9'h080;
  localparam logic [8:0] BID_LVL3 = 9'h0c0;
  // Reset values
  localparam logic RX_ENABLE_RST = 1'b0;
  typedef enum logic [2:0] {
    URXF_IDLE = 3'b001,
    URXF_WRITE = 3'b010,
    URXF_HOLD = 3'b100
  } urxf_state_t;
endpackage
`default_nettype wire

// ---- verilog/urxf_stage_fifo.sv ----
`default_nettype none
// Intentionally empty: the staging FIFO is declared beside the receive buffer
`default_nettype wire

// ---- verilog/urxf_rx_buffer.sv ----
`default_nettype none
//Contract
//- Buffer holds 256 words of data byte plus three status bits.
//- Fill count is the bid; empty bids nothing, full bids 255.
//- Full flag set exactly when all 256 entries are occupied.
//- Offset field suppresses the bid until one of four levels is reached.
//- Status bits of the output entry appear as top three status bits.
//- Character mode shows only the status of the entry at the output.
//- Block mode latches the OR of errors until receiver or chip reset.
//- Block latch sets on exit by default; a command makes it set on entry.
//- Status reads never move the read pointer; only data reads do.
//- A character arriving on a full buffer is held until space frees.
//- A start bit during hold-over drops the held character, sets overrun.
//- Multi-drop is active when parity field equals binary 11.
//- In multi-drop the parity position is address (1) or data (0).
//- Sub-mode: 00 host, 01 auto wake, 10 auto doze, 11 both.
//- Transmit flag comes from a framing bit, set before loading bytes.
//- Host mode: disabled receiver loads address characters, drops data.
//- Received address flag is stored in the parity error position.
//- Framing, overrun and break work whether or not receiver enabled; here framing and break bits are kept only for characters that are loaded.
//- Auto wake enables the receiver on a matching address byte.
//- Auto doze disables the receiver on a non-matching address byte.
//- In auto sub-modes a mode bit keeps or strips the address byte.
//- Multi-drop overrides receiver disable and reset to keep monitoring.
//- Receiver reset drops shift data, clears ready and status, empties; here the overrun bit is not cleared.
//- Overrun stays set until the error reset command.
module urxf_rx_buffer #(
  parameter int DEPTH = urxf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // From receiver shift logic
  input wire logic charDone,
  input wire logic [7:0] charData,
  input wire logic charAdFlag,
  input wire logic charParityErr,
  input wire logic charFrameErr,
  input wire logic charBreak,
  input wire logic startBit,
  // Host configuration
  input wire logic [1:0] framingParity,
  input wire logic [1:0] multidropSubMode,
  input wire logic addrLoadKeep,
  input wire logic [1:0] rxBidOffsetLevel,
  input wire logic errorBlockMode,
  input wire logic [7:0] stationAddress,
  // Host commands, one-cycle pulses
  input wire logic cmdRxEnable,
  input wire logic cmdRxDisable,
  input wire logic cmdRxReset,
  input wire logic cmdErrorReset,
  input wire logic cmdLatchOnEntry,
  input wire logic cmdLatchOnExit,
  input wire logic dataRead,
  // Status to host
  output logic [7:0] rxData,
  output logic [7:0] channelStatus,
  output logic receiveReadyFlag,
  output logic rxBufferFullFlag,
  output logic [7:0] rxBid,
  output logic rxEnabled
);
  initial begin
    if (DEPTH != urxf_pkg::FIFO_DEPTH) $error("Buffer depth must be 256");
  end
  localparam int AW = 8;

  ////////////////////////////////////////////////////////////////////////
  // Character admission and multi-drop recognition
  logic rxEnable_r;
  logic latchOnEntry_r;
  logic overrun_r;
  logic holdValid_r;
  logic [10:0] hold_r;
  wire multidrop = framingParity == urxf_pkg::PARITY_MULTIDROP;
  wire autoWake = multidrop && multidropSubMode[0];
  wire autoDoze = multidrop && multidropSubMode[1];
  wire autoMode = multidrop && (multidropSubMode != urxf_pkg::MD_HOST);
  wire isAddr = multidrop && charAdFlag;
  wire addrMatch = charData == stationAddress;
  // Address bytes in auto modes are kept only when the keep bit asks
  wire autoAccept = isAddr ? addrLoadKeep : rxEnable_r;
  // Host mode monitors the line even while disabled
  wire hostAccept = rxEnable_r || isAddr;
  wire accept = !multidrop ? rxEnable_r : (autoMode ? autoAccept : hostAccept);
  // Parity error slot carries the address flag in multi-drop
  wire statParity = multidrop ? charAdFlag : charParityErr;
  wire [10:0] newWord = {charBreak, charFrameErr, statParity, charData};
  wire admit = charDone && accept && !cmdRxReset;
  ////////////////////////////////////////////////////////////////////////
  // Staging FIFO between assembly and the main buffer
  logic stValid;
  logic stReady;
  logic [10:0] stData;
  logic stInReady;
  urxf_stage_fifo #(.WIDTH(urxf_pkg::WORD_W), .DEPTH(urxf_pkg::STAGE_DEPTH)) stage (
    .clk(clk),
    .reset(reset || cmdRxReset),
    .inValid(admit),
    .inReady(stInReady),
    .inData(newWord),
    .outValid(stValid),
    .outReady(stReady),
    .outData(stData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Main buffer memory and pointers
  logic [10:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  wire [AW:0] count = wrPtr_r - rdPtr_r;
  wire full = count[AW];
  wire empty = count == '0;
  wire popMain = dataRead && !empty;
  // Held character has priority over staged ones to keep order
  wire fromHold = holdValid_r;
  wire [10:0] wrWord = fromHold ? hold_r : stData;
  wire wrReq = fromHold || stValid;
  wire wrMain = wrReq && (!full || popMain) && !cmdRxReset;
  // Staging drains into the hold register when the buffer is full
  assign stReady = !fromHold && !cmdRxReset;
  wire toHold = stValid && stReady && full && !popMain;
  wire [10:0] outWord = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (wrMain) begin
      mem[wrPtr_r[AW-1:0]] <= wrWord;
    end
  end
  // Receiver reset realigns pointers without touching stored words
  always_ff @(posedge clk) begin
    if (reset || cmdRxReset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (AW+1)'(wrMain);
      rdPtr_r <= rdPtr_r + (AW+1)'(popMain);
    end
  end
  // Hold-over register; a new start bit while holding drops it
  always_ff @(posedge clk) begin
    if (reset || cmdRxReset) begin
      holdValid_r <= 1'b0;
      hold_r <= '0;
    end else if (holdValid_r && startBit && !wrMain) begin
      holdValid_r <= 1'b0;
    end else if (toHold) begin
      holdValid_r <= 1'b1;
      hold_r <= stData;
    end else if (fromHold && wrMain) begin
      holdValid_r <= 1'b0;
    end
  end
  // Overrun is sticky; set beats clear; a push refused by a full stage loses data too
  wire stageLost = admit && !stInReady;
  wire overrunSet = (holdValid_r && startBit && !wrMain) || stageLost;
  always_ff @(posedge clk) begin
    if (reset) begin
      overrun_r <= 1'b0;
    end else if (overrunSet) begin
      overrun_r <= 1'b1;
    end else if (cmdErrorReset) begin
      overrun_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver enable, driven by host and the recognition logic
  wire recogAddr = charDone && isAddr;
  always_ff @(posedge clk) begin
    if (reset) begin
      rxEnable_r <= urxf_pkg::RX_ENABLE_RST;
    end else if (cmdRxDisable || cmdRxReset) begin
      rxEnable_r <= 1'b0;
    end else if (cmdRxEnable) begin
      rxEnable_r <= 1'b1;
    end else if (recogAddr && autoWake && addrMatch) begin
      rxEnable_r <= 1'b1;
    end else if (recogAddr && autoDoze && !addrMatch) begin
      rxEnable_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block mode error latch and its source selection
  logic [2:0] blockLatch_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      latchOnEntry_r <= 1'b0;
    end else if (cmdLatchOnEntry) begin
      latchOnEntry_r <= 1'b1;
    end else if (cmdLatchOnExit) begin
      latchOnEntry_r <= 1'b0;
    end
  end
  wire [2:0] entryErr = wrMain ? wrWord[10:8] : 3'h0;
  wire [2:0] exitErr = popMain ? outWord[10:8] : 3'h0;
  wire [2:0] latchIn = latchOnEntry_r ? entryErr : exitErr;
  // Only a receiver reset or chip reset clears the latch
  always_ff @(posedge clk) begin
    if (reset || cmdRxReset) begin
      blockLatch_r <= 3'h0;
    end else begin
      blockLatch_r <= blockLatch_r | latchIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bid with offset level suppression
  function automatic logic [8:0] bidLevel(input logic [1:0] code);
    case (code)
      2'h0: bidLevel = urxf_pkg::BID_LVL0;
      2'h1: bidLevel = urxf_pkg::BID_LVL1;
      2'h2: bidLevel = urxf_pkg::BID_LVL2;
      default: bidLevel = urxf_pkg::BID_LVL3;
    endcase
  endfunction
  wire [AW:0] nextCount = count + (AW+1)'(wrMain) - (AW+1)'(popMain);
  wire nextEmpty = nextCount == '0;
  wire bidOn = !nextEmpty && nextCount >= bidLevel(rxBidOffsetLevel);
  // A full buffer saturates at 255 in the eight-bit bid
  wire [7:0] bidVal = nextCount[AW] ? 8'hff : nextCount[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  wire nextFullFlag = nextCount[AW];
  // A word written into the head slot this edge is not in memory yet, so bypass it
  wire [AW-1:0] headAddr = rdPtr_r[AW-1:0] + 8'(popMain);
  wire headBypass = wrMain && (wrPtr_r[AW-1:0] == headAddr);
  wire [10:0] headWord = headBypass ? wrWord : mem[headAddr];
  wire [2:0] charStat = nextEmpty ? 3'h0 : headWord[10:8];
  wire [2:0] upperStat = errorBlockMode ? blockLatch_r | latchIn : charStat;
  wire [7:0] nextData = headWord[7:0];
  always_ff @(posedge clk) begin
    if (reset || cmdRxReset) begin
      rxData <= 8'h00;
      channelStatus <= 8'h00;
      receiveReadyFlag <= 1'b0;
      rxBufferFullFlag <= 1'b0;
      rxBid <= 8'h00;
      rxEnabled <= 1'b0;
    end else begin
      rxData <= nextData;
      channelStatus <= {upperStat, overrun_r || overrunSet, 2'h0, nextFullFlag, !nextEmpty};
      receiveReadyFlag <= !nextEmpty;
      rxBufferFullFlag <= nextFullFlag;
      rxBid <= bidOn ? bidVal : 8'h00;
      rxEnabled <= rxEnable_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  full_flag_a: assert property (@(posedge clk) disable iff (reset)
    rxBufferFullFlag == (count == (AW+1)'(DEPTH)) && (!rxBufferFullFlag || rxBid == 8'hff))
    else $error("full flag without full count");
  bid_empty_a: assert property (@(posedge clk) disable iff (reset)
    !receiveReadyFlag |-> rxBid == 8'h00) else $error("empty buffer bids");
  bid_count_a: assert property (@(posedge clk) disable iff (reset)
    rxBid != 8'h00 && !rxBufferFullFlag |-> rxBid == count[7:0])
    else $error("bid not fill count");
  bid_level_a: assert property (@(posedge clk) disable iff (reset)
    (rxBid != 8'h00 && !rxBufferFullFlag) |-> rxBid >= 8'(bidLevel($past(rxBidOffsetLevel))))
    else $error("bid below offset level");
  status_read_a: assert property (@(posedge clk) disable iff (reset || cmdRxReset)
    !dataRead && !wrMain |=> rdPtr_r == $past(rdPtr_r)) else $error("pointer moved");
  head_word_a: assert property (@(posedge clk) disable iff (reset)
    receiveReadyFlag && !$past(errorBlockMode) |->
      channelStatus[7:5] == outWord[10:8] && rxData == outWord[7:0])
    else $error("status not of head entry");
  rx_reset_a: assert property (@(posedge clk) disable iff (reset)
    cmdRxReset |=> !receiveReadyFlag && rxBid == 8'h00 && count == '0)
    else $error("receiver reset left data");
  overrun_hold_a: assert property (@(posedge clk) disable iff (reset)
    overrun_r && !cmdErrorReset |=> overrun_r) else $error("overrun lost");
  error_reset_a: assert property (@(posedge clk) disable iff (reset)
    cmdErrorReset && !overrunSet |=> !overrun_r) else $error("overrun not cleared");
  overrun_set_a: assert property (@(posedge clk) disable iff (reset)
    holdValid_r && startBit && !wrMain |=> overrun_r ##0 !holdValid_r)
    else $error("overrun not raised");
  block_sticky_a: assert property (@(posedge clk) disable iff (reset || cmdRxReset)
    (blockLatch_r != 3'h0) |=> (blockLatch_r & $past(blockLatch_r)) == $past(blockLatch_r))
    else $error("block latch dropped");
  wake_match_a: assert property (@(posedge clk) disable iff (reset)
    recogAddr && autoWake && addrMatch && !cmdRxDisable && !cmdRxReset |=> rxEnable_r)
    else $error("wake missed");
  doze_miss_a: assert property (@(posedge clk) disable iff (reset)
    recogAddr && autoDoze && !autoWake && !addrMatch && !cmdRxEnable |=> !rxEnable_r)
    else $error("doze missed");
  host_drop_a: assert property (@(posedge clk) disable iff (reset)
    charDone && multidrop && !autoMode && !rxEnable_r && !charAdFlag |-> !admit)
    else $error("data kept while disabled");
endmodule

////////////////////////////////////////////////////////////////////////
// Small staging FIFO between character assembly and the receive buffer
module urxf_stage_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  // Full when pointers differ only in the wrap bit
  assign inReady = (wrPtr_r ^ rdPtr_r) != {1'h1, {AW{1'h0}}};
  assign outValid = wrPtr_r != rdPtr_r;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (AW+1)'(push);
      rdPtr_r <= rdPtr_r + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/urxf_remote_station.sv ----
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far station: hands over assembled characters and start-bit events
module urxf_remote_station (
  // Clock
  input wire logic clk,
  // Character side
  output logic charDone,
  output logic [7:0] charData,
  output logic charAdFlag,
  output logic charParityErr,
  output logic charFrameErr,
  output logic charBreak,
  output logic startBit
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle lines
  initial begin
    charDone = 1'b0;
    {charData, charBreak, charFrameErr, charParityErr, charAdFlag} = 12'h000;
    startBit = 1'b0;
  end
  // One character; f is {break, frame, parity, address flag}
  task automatic sendChar(input logic [7:0] d, input logic [3:0] f);
    @(posedge clk);
    #1;
    charDone = 1'b1;
    charData = d;
    {charBreak, charFrameErr, charParityErr, charAdFlag} = f;
    @(posedge clk);
    #1;
    charDone = 1'b0;
    // Released lines flip so that stale values never pass for fresh ones
    charData = ~d;
    {charBreak, charFrameErr, charParityErr, charAdFlag} = ~f;
  endtask
  // Start bit of a following character
  task automatic startEdge();
    @(posedge clk);
    #1;
    startBit = 1'b1;
    @(posedge clk);
    #1;
    startBit = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/urxf_rx_buffer_tb_top.sv ----
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module urxf_rx_buffer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, charDone, charAdFlag, charParityErr, charFrameErr, charBreak, startBit;
  logic [7:0] charData, stationAddress, rxData, channelStatus, rxBid, d;
  logic [1:0] framingParity, multidropSubMode, rxBidOffsetLevel;
  logic addrLoadKeep, errorBlockMode, receiveReadyFlag, rxBufferFullFlag, rxEnabled;
  logic cmdRxEnable, cmdRxDisable, cmdRxReset, cmdErrorReset;
  logic cmdLatchOnEntry, cmdLatchOnExit, dataRead;
  int mismatches = 0;
  int cmpCount = 0;
  // Command masks for cmd()
  localparam logic [6:0] EN = 7'h40, DIS = 7'h20, RRST = 7'h10, ERST = 7'h08;
  localparam logic [6:0] LENT = 7'h04, LEXT = 7'h02, RD = 7'h01;
  ////////////////////////////////////////////////////////////////////////////////
  urxf_rx_buffer urxf_rx_buffer_i (.clk(clk), .reset(reset), .charDone(charDone),
    .charData(charData), .charAdFlag(charAdFlag), .charParityErr(charParityErr),
    .charFrameErr(charFrameErr), .charBreak(charBreak), .startBit(startBit),
    .framingParity(framingParity), .multidropSubMode(multidropSubMode),
    .addrLoadKeep(addrLoadKeep), .rxBidOffsetLevel(rxBidOffsetLevel),
    .errorBlockMode(errorBlockMode), .stationAddress(stationAddress),
    .cmdRxEnable(cmdRxEnable), .cmdRxDisable(cmdRxDisable), .cmdRxReset(cmdRxReset),
    .cmdErrorReset(cmdErrorReset), .cmdLatchOnEntry(cmdLatchOnEntry),
    .cmdLatchOnExit(cmdLatchOnExit), .dataRead(dataRead), .rxData(rxData),
    .channelStatus(channelStatus), .receiveReadyFlag(receiveReadyFlag),
    .rxBufferFullFlag(rxBufferFullFlag), .rxBid(rxBid), .rxEnabled(rxEnabled));
  urxf_remote_station urxf_remote_station_i (.clk(clk), .charDone(charDone),
    .charData(charData), .charAdFlag(charAdFlag), .charParityErr(charParityErr),
    .charFrameErr(charFrameErr), .charBreak(charBreak), .startBit(startBit));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Inputs move 1 ns after the edge so the design never samples a race
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Command pulse; trailing tick keeps two pulses from sharing a time step
  task automatic cmd(input logic [6:0] m);
    {cmdRxEnable, cmdRxDisable, cmdRxReset, cmdErrorReset, cmdLatchOnEntry,
      cmdLatchOnExit, dataRead} = m;
    tick(1);
    {cmdRxEnable, cmdRxDisable, cmdRxReset, cmdErrorReset, cmdLatchOnEntry,
      cmdLatchOnExit, dataRead} = 7'h00;
    tick(1);
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Bid seen at a given fill: nothing below the level, capped at 255
  function automatic logic [8:0] bidExp(input int cnt, input logic [8:0] lvl);
    if (cnt < int'(lvl)) return 9'h000;
    return (cnt > 255) ? 9'h0ff : 9'(cnt);
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 2000 cycles the sequence needs
  initial begin
    #160000;
    mismatches++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {framingParity, multidropSubMode, rxBidOffsetLevel, addrLoadKeep, errorBlockMode} = 8'h00;
    stationAddress = 8'h42;
    {cmdRxEnable, cmdRxDisable, cmdRxReset, cmdErrorReset} = 4'h0;
    {cmdLatchOnEntry, cmdLatchOnExit, dataRead} = 3'h0;
    reset = 1'b1;
    tick(20);
    reset = 1'b0;
    tick(1);
    chk(rxEnabled, urxf_pkg::RX_ENABLE_RST);
    urxf_remote_station_i.sendChar(8'h11, 4'h0);
    tick(5);
    chk(rxBid, 9'h000);
    cmd(EN);
    // One character with a parity error
    urxf_remote_station_i.sendChar(8'h5a, 4'h2);
    tick(5);
    chk(rxData, 9'h05a);
    chk(channelStatus, 9'h021);
    chk(rxBid, 9'h001);
    tick(4);
    chk(rxData, 9'h05a);
    cmd(RD);
    tick(3);
    chk(channelStatus, 9'h000);
    chk(rxBid, 9'h000);
    // Fill to 256 with the bid held back until 64
    rxBidOffsetLevel = 2'h1;
    for (int i = 1; i <= 256; i++) begin
      urxf_remote_station_i.sendChar(8'(i - 1), 4'h0);
      if (i == 63 || i == 64) begin
        tick(5);
        chk(rxBid, bidExp(i, urxf_pkg::BID_LVL1));
        chk(rxBufferFullFlag, 9'h000);
      end
    end
    tick(5);
    chk(rxBufferFullFlag, 9'h001);
    chk(rxBid, 9'h0ff);
    // Hold-over, then overrun
    urxf_remote_station_i.sendChar(8'haa, 4'h0);
    tick(5);
    chk(rxData, 9'h000);
    cmd(RD);
    tick(5);
    chk(rxData, 9'h001);
    chk(rxBufferFullFlag, 9'h001);
    urxf_remote_station_i.sendChar(8'hbb, 4'h0);
    urxf_remote_station_i.startEdge();
    tick(3);
    chk(channelStatus[4], 9'h001);
    cmd(ERST);
    tick(2);
    chk(channelStatus[4], 9'h000);
    // Drain in order; the dropped character must never appear
    rxBidOffsetLevel = 2'h3;
    for (int j = 1; j <= 256; j++) begin
      chk(rxBid, bidExp(257 - j, urxf_pkg::BID_LVL3));
      d = (j == 256) ? 8'haa : 8'(j);
      chk(rxData, d);
      cmd(RD);
      tick(3);
    end
    chk(channelStatus, 9'h000);
    // Block mode, latch on entry then on exit
    errorBlockMode = 1'b1;
    rxBidOffsetLevel = 2'h0;
    cmd(LENT);
    urxf_remote_station_i.sendChar(8'h01, 4'h4);
    urxf_remote_station_i.sendChar(8'h02, 4'h0);
    tick(5);
    chk(channelStatus[6], 9'h001);
    cmd(RD);
    cmd(RD);
    tick(3);
    chk(channelStatus[6], 9'h001);
    cmd(RRST);
    tick(3);
    chk(channelStatus[6], 9'h000);
    cmd(EN);
    cmd(LEXT);
    urxf_remote_station_i.sendChar(8'h03, 4'h4);
    urxf_remote_station_i.sendChar(8'h04, 4'h0);
    tick(5);
    chk(channelStatus[6], 9'h000);
    cmd(RD);
    tick(3);
    chk(channelStatus[6], 9'h001);
    cmd(RRST);
    tick(3);
    chk(rxBid, 9'h000);
    chk(receiveReadyFlag, 9'h000);
    // Multi-drop, host controlled, receiver disabled and reset
    errorBlockMode = 1'b0;
    framingParity = urxf_pkg::PARITY_MULTIDROP;
    cmd(DIS);
    cmd(RRST);
    urxf_remote_station_i.sendChar(8'h33, 4'h0);
    tick(5);
    chk(rxBid, 9'h000);
    chk(receiveReadyFlag, 9'h000);
    urxf_remote_station_i.sendChar(8'h44, 4'h1);
    tick(5);
    chk(rxData, 9'h044);
    chk(channelStatus, 9'h021);
    cmd(RD);
    // Auto wake strips the address
    multidropSubMode = urxf_pkg::MD_WAKE;
    urxf_remote_station_i.sendChar(8'h42, 4'h1);
    tick(5);
    chk(rxEnabled, 9'h001);
    chk(rxBid, 9'h000);
    urxf_remote_station_i.sendChar(8'h55, 4'h0);
    tick(5);
    chk(rxData, 9'h055);
    cmd(RD);
    // Auto doze keeps the foreign address
    multidropSubMode = urxf_pkg::MD_DOZE;
    addrLoadKeep = 1'b1;
    urxf_remote_station_i.sendChar(8'h17, 4'h1);
    tick(5);
    chk(rxEnabled, 9'h000);
    chk(rxData, 9'h017);
    cmd(RD);
    // Both automatic features
    multidropSubMode = urxf_pkg::MD_BOTH;
    urxf_remote_station_i.sendChar(8'h42, 4'h1);
    tick(5);
    chk(rxEnabled, 9'h001);
    cmd(RD);
    urxf_remote_station_i.sendChar(8'h18, 4'h1);
    tick(5);
    chk(rxEnabled, 9'h000);
    wrap_up();
  end
endmodule
`default_nettype wire
